// File: rtl/aju_pkg.sv
package aju_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFS_CFG        = 8'h00;
  localparam logic [7:0] OFS_TOT_LIM    = 8'h04;
  localparam logic [7:0] OFS_SEAT_LIM   = 8'h08;
  localparam logic [7:0] OFS_FREE_LIM   = 8'h0c;
  localparam logic [7:0] OFS_SEAT_TRQ   = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_ANGLES     = 8'h18;
  localparam logic [7:0] OFS_FREE_ANGLE = 8'h1c;
  localparam logic [7:0] OFS_CONTROL    = 8'h20;

  // Configuration, limit and control field positions.
  localparam int CFG_JUDG_LSB  = 0;
  localparam int CFG_FREE_LSB  = 2;
  localparam int CFG_SEAT_ANG  = 4;
  localparam int CFG_SEAT_TRQ  = 5;
  localparam int CFG_LIM_AUTO  = 6;
  localparam int CFG_FAST_AUTO = 7;
  localparam int CFG_RPT_LSB   = 8;
  localparam int CFG_MODE_LSB  = 12;
  localparam int HI_LSB        = 16;
  localparam int CTL_RESET     = 0;

  // Selection codes.
  localparam logic [1:0] SEL_OFF  = 2'h0;
  localparam logic [1:0] SEL_ERR  = 2'h1;
  localparam logic [1:0] SEL_WARN = 2'h2;
  localparam logic [3:0] MODE_ANGLE_CTRL = 4'h6;

  // Reset values of the settings.
  localparam logic [9:0]  ANG_MAX      = 10'h3e7;
  localparam logic [9:0]  ANG_ZERO     = 10'h000;
  localparam logic [13:0] FREE_ZERO    = 14'h0000;
  localparam logic [13:0] TRQ_DEFAULT  = 14'h0000;
  localparam logic [31:0] CFG_DEFAULT  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FREE  = 3'b001,
    ST_START = 3'b010,
    ST_SEAT  = 3'b011,
    ST_DONE  = 3'b100
  } aju_state_type;

  // Verdict bundle.
  typedef struct packed {
    logic tot_high;
    logic tot_low;
    logic seat_trq;
    logic seat_low;
    logic seat_high;
    logic free_low;
  } aju_flags_type;

  typedef struct packed {
    logic fail_line;
    logic pass_line;
    logic buzzer;
    logic valve_close;
    logic count_dec;
    logic lamp_off;
  } aju_out_type;

endpackage

// File: rtl/aju_angle_judgment.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Total angle above high limit fails
// - Angle-high failure closes the valve
// - Fail line held until error reset
// - Limit errors cleared by reset inputs
// - Seating torque starts angle measurement
// - Stop angle stored, inactive feature
// - Seating torque missing at timer expiry flags
// - Judgment select: fail or warn plus count
// - Fail line for error, pass for warning
// - Seating errors cleared by start or reset
// - Seating angle judged against both limits
// - Seating warning passes and decrements count
// - Seating angle below low limit reported
// - Seating angle above high limit reported
// - Report select picks reported segments
// - Free-run angle below limit checked
// - Free-run warning passes and decrements count
// - Angle judgment select zero, one, two
// - Seating or free-run error: lamp off, buzzer
// - Total angle below low limit fails
// - Free-run low limit used as threshold
module aju_angle_judgment (
  // Clock and reset.
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        clk_en,
  // AHB-Lite slave.
  input  wire  logic        hsel,
  input  wire  logic [7:0]  haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Tool measurement.
  input  wire  logic        trigger,
  input  wire  logic        start_torque_hit,
  input  wire  logic [13:0] torque,
  input  wire  logic        angle_pulse,
  input  wire  logic        seat_timer_done,
  input  wire  logic        judge_now,
  // External controller side.
  input  wire  logic        ext_reset,
  input  wire  logic        panel_reset_key,
  // Verdict outputs.
  output logic              fail_output_line,
  output logic              pass_output_line,
  output logic              buzzer,
  output logic              valve_close,
  output logic              count_dec,
  output logic              torque_lamp_off,
  output logic [5:0]        error_flags
);

  logic [31:0]   cfg_ff;
  logic [9:0]    tot_low_ff, total_angle_high_limit_ff;
  logic [9:0]    seating_angle_low_limit_ff, seating_angle_high_limit_ff;
  logic [13:0]   free_low_ff, seating_torque_threshold_ff;
  logic [9:0]    stop_angle_value_ff;
  logic [13:0]   free_cnt_ff;
  logic [9:0]    seat_cnt_ff, tot_cnt_ff;
  aju_pkg::aju_state_type state_ff, nxt_state;
  aju_pkg::aju_flags_type err_ff, warn_ff, nxt_err, nxt_warn;
  aju_pkg::aju_out_type   out_ff, nxt_out;
  logic          ap_valid_ff, ap_write_ff;
  logic [7:0]    ap_addr_ff;
  logic          sw_reset_ff;

  logic [1:0] angle_judgment_select, freerun_check_select, angle_report_select;
  logic [3:0] tightening_selection;
  logic       seating_angle_check_select, seat_trq_check, lim_auto, fast_auto;
  assign angle_judgment_select      = cfg_ff[aju_pkg::CFG_JUDG_LSB +: 2];
  assign freerun_check_select       = cfg_ff[aju_pkg::CFG_FREE_LSB +: 2];
  assign seating_angle_check_select = cfg_ff[aju_pkg::CFG_SEAT_ANG];
  assign seat_trq_check             = cfg_ff[aju_pkg::CFG_SEAT_TRQ];
  assign lim_auto                   = cfg_ff[aju_pkg::CFG_LIM_AUTO];
  assign fast_auto                  = cfg_ff[aju_pkg::CFG_FAST_AUTO];
  assign angle_report_select        = cfg_ff[aju_pkg::CFG_RPT_LSB +: 2];
  assign tightening_selection       = cfg_ff[aju_pkg::CFG_MODE_LSB +: 4];

  // A zero limit disables its check.
  function automatic logic below(input logic [13:0] val, input logic [13:0] lim);
    below = (lim != 14'h0000) && (val < lim);
  endfunction

  function automatic logic above(input logic [13:0] val, input logic [13:0] lim);
    above = (lim != 14'h0000) && (val > lim);
  endfunction

  logic any_reset, start_evt, seat_reach, wr_en, rd_en;
  assign any_reset  = ext_reset | panel_reset_key | sw_reset_ff;
  assign start_evt  = trigger && (state_ff == aju_pkg::ST_IDLE || state_ff == aju_pkg::ST_DONE);
  assign seat_reach = (torque >= seating_torque_threshold_ff);
  assign wr_en      = ap_valid_ff & ap_write_ff;
  assign rd_en      = hsel & hready & htrans[1] & ~hwrite;

  // Bus address phase capture; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff  <= 8'h00;
    end else if (clk_en && hready) begin
      ap_valid_ff <= hsel & htrans[1];
      ap_write_ff <= hwrite;
      ap_addr_ff  <= haddr;
    end
  end

  // Settings registers written in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff                      <= aju_pkg::CFG_DEFAULT;
      tot_low_ff                  <= aju_pkg::ANG_ZERO;
      total_angle_high_limit_ff   <= aju_pkg::ANG_ZERO;
      seating_angle_low_limit_ff  <= aju_pkg::ANG_ZERO;
      seating_angle_high_limit_ff <= aju_pkg::ANG_MAX;
      free_low_ff                 <= aju_pkg::FREE_ZERO;
      seating_torque_threshold_ff <= aju_pkg::TRQ_DEFAULT;
      stop_angle_value_ff         <= aju_pkg::ANG_MAX;
      sw_reset_ff                 <= 1'b0;
    end else if (clk_en) begin
      sw_reset_ff <= wr_en && ap_addr_ff == aju_pkg::OFS_CONTROL && hwdata[aju_pkg::CTL_RESET];
      if (wr_en) begin
        case (ap_addr_ff)
          aju_pkg::OFS_CFG: begin
            cfg_ff <= hwdata;
          end
          aju_pkg::OFS_TOT_LIM: begin
            tot_low_ff                <= hwdata[9:0];
            total_angle_high_limit_ff <= hwdata[aju_pkg::HI_LSB +: 10];
          end
          aju_pkg::OFS_SEAT_LIM: begin
            seating_angle_low_limit_ff  <= hwdata[9:0];
            seating_angle_high_limit_ff <= hwdata[aju_pkg::HI_LSB +: 10];
          end
          aju_pkg::OFS_FREE_LIM: begin
            free_low_ff <= hwdata[13:0];
          end
          aju_pkg::OFS_SEAT_TRQ: begin
            seating_torque_threshold_ff <= hwdata[13:0];
            stop_angle_value_ff         <= hwdata[aju_pkg::HI_LSB +: 10];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && rd_en) begin
      case (haddr)
        aju_pkg::OFS_CFG:        hrdata <= cfg_ff;
        aju_pkg::OFS_TOT_LIM:    hrdata <= {6'h00, total_angle_high_limit_ff, 6'h00, tot_low_ff};
        aju_pkg::OFS_SEAT_LIM:   hrdata <= {6'h00, seating_angle_high_limit_ff,
                                            6'h00, seating_angle_low_limit_ff};
        aju_pkg::OFS_FREE_LIM:   hrdata <= {18'h00000, free_low_ff};
        aju_pkg::OFS_SEAT_TRQ:   hrdata <= {6'h00, stop_angle_value_ff, 2'h0,
                                            seating_torque_threshold_ff};
        aju_pkg::OFS_STATUS:     hrdata <= {13'h0000, state_ff, 2'h0, warn_ff, 2'h0, err_ff};
        // Segments not chosen by the report select read as zero.
        aju_pkg::OFS_ANGLES:     hrdata <= {6'h00,
                                   (angle_report_select[0] ? seat_cnt_ff : aju_pkg::ANG_ZERO),
                                   6'h00, tot_cnt_ff};
        aju_pkg::OFS_FREE_ANGLE: hrdata <= {18'h00000, (angle_report_select[1] ? free_cnt_ff
                                   : aju_pkg::FREE_ZERO)};
        default:                 hrdata <= 32'h0000_0000;
      endcase
      // A read right behind a write to the same word must see the new value, since
      // the register itself only takes it at this same edge.
      if (wr_en && ap_addr_ff == haddr) begin
        case (haddr)
          aju_pkg::OFS_CFG: begin
            hrdata <= hwdata;
          end
          aju_pkg::OFS_TOT_LIM, aju_pkg::OFS_SEAT_LIM: begin
            hrdata <= {6'h00, hwdata[aju_pkg::HI_LSB +: 10], 6'h00, hwdata[9:0]};
          end
          aju_pkg::OFS_FREE_LIM: begin
            hrdata <= {18'h00000, hwdata[13:0]};
          end
          aju_pkg::OFS_SEAT_TRQ: begin
            hrdata <= {6'h00, hwdata[aju_pkg::HI_LSB +: 10], 2'h0, hwdata[13:0]};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Held in flip-flops so every port leaves a register.
  // The slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Fastening sequence and angle accumulation.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      aju_pkg::ST_IDLE, aju_pkg::ST_DONE: begin
        if (trigger) nxt_state = aju_pkg::ST_FREE;
      end
      aju_pkg::ST_FREE: begin
        if (start_torque_hit) nxt_state = aju_pkg::ST_START;
      end
      aju_pkg::ST_START: begin
        if (seat_reach) nxt_state = aju_pkg::ST_SEAT;
        else if (judge_now) nxt_state = aju_pkg::ST_DONE;
      end
      aju_pkg::ST_SEAT: begin
        if (judge_now) nxt_state = aju_pkg::ST_DONE;
      end
      default: nxt_state = aju_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_ff <= aju_pkg::ST_IDLE;
    else if (clk_en) state_ff <= nxt_state;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      free_cnt_ff <= aju_pkg::FREE_ZERO;
      seat_cnt_ff <= aju_pkg::ANG_ZERO;
      tot_cnt_ff  <= aju_pkg::ANG_ZERO;
    end else if (clk_en) begin
      if (start_evt) begin
        free_cnt_ff <= aju_pkg::FREE_ZERO;
        seat_cnt_ff <= aju_pkg::ANG_ZERO;
        tot_cnt_ff  <= aju_pkg::ANG_ZERO;
      end else if (angle_pulse) begin
        // Counters saturate rather than wrap so a runaway never looks short.
        if (state_ff == aju_pkg::ST_FREE && free_cnt_ff != 14'h3fff)
          free_cnt_ff <= free_cnt_ff + 14'h0001;
        if (state_ff == aju_pkg::ST_START && seat_cnt_ff != 10'h3ff)
          seat_cnt_ff <= seat_cnt_ff + 10'h001;
        if (state_ff == aju_pkg::ST_SEAT && tot_cnt_ff != 10'h3ff)
          tot_cnt_ff <= tot_cnt_ff + 10'h001;
      end
    end
  end

  // Verdicts. The high limit is checked live so the valve closes at once.
  logic judge_pt, judg_on, hi_now, stop_now;
  assign judge_pt = judge_now && (state_ff == aju_pkg::ST_START || state_ff == aju_pkg::ST_SEAT);
  assign judg_on  = (angle_judgment_select != aju_pkg::SEL_OFF);
  // A count held after the seated phase must not undo a reset of the error.
  assign hi_now   = judg_on && state_ff == aju_pkg::ST_SEAT
                    && above({4'h0, tot_cnt_ff}, {4'h0, total_angle_high_limit_ff});
  // Stop angle is kept for angle control but left inert for now.
  assign stop_now = 1'b0 && tightening_selection == aju_pkg::MODE_ANGLE_CTRL
                    && tot_cnt_ff >= stop_angle_value_ff;

  always_comb begin
    aju_pkg::aju_flags_type ev;
    ev = '0;
    ev.tot_high  = hi_now;
    if (judge_pt) begin
      ev.tot_low   = judg_on && below({4'h0, tot_cnt_ff}, {4'h0, tot_low_ff});
      ev.seat_low  = judg_on && seating_angle_check_select
                     && below({4'h0, seat_cnt_ff}, {4'h0, seating_angle_low_limit_ff});
      ev.seat_high = judg_on && seating_angle_check_select
                     && above({4'h0, seat_cnt_ff}, {4'h0, seating_angle_high_limit_ff});
      ev.free_low  = (freerun_check_select != aju_pkg::SEL_OFF)
                     && below(free_cnt_ff, free_low_ff);
    end
    ev.seat_trq = judg_on && seat_trq_check && seat_timer_done
                  && !seat_reach && state_ff == aju_pkg::ST_START;
    nxt_err  = err_ff;
    nxt_warn = warn_ff;
    // Clears go first so a fresh event in the same cycle still lands.
    if (any_reset) begin
      nxt_err  = '0;
      nxt_warn = '0;
    end else if (start_evt) begin
      if (lim_auto) begin
        nxt_err.tot_high = 1'b0;
        nxt_err.tot_low  = 1'b0;
      end
      if (fast_auto) begin
        nxt_err.seat_trq  = 1'b0;
        nxt_err.seat_low  = 1'b0;
        nxt_err.seat_high = 1'b0;
        nxt_err.free_low  = 1'b0;
      end
      nxt_warn = '0;
    end
    if (angle_judgment_select == aju_pkg::SEL_ERR) begin
      nxt_err.tot_high  = nxt_err.tot_high  | ev.tot_high;
      nxt_err.tot_low   = nxt_err.tot_low   | ev.tot_low;
      nxt_err.seat_trq  = nxt_err.seat_trq  | ev.seat_trq;
      nxt_err.seat_low  = nxt_err.seat_low  | ev.seat_low;
      nxt_err.seat_high = nxt_err.seat_high | ev.seat_high;
    end else begin
      nxt_warn.tot_high  = nxt_warn.tot_high  | ev.tot_high;
      nxt_warn.tot_low   = nxt_warn.tot_low   | ev.tot_low;
      nxt_warn.seat_trq  = nxt_warn.seat_trq  | ev.seat_trq;
      nxt_warn.seat_low  = nxt_warn.seat_low  | ev.seat_low;
      nxt_warn.seat_high = nxt_warn.seat_high | ev.seat_high;
    end
    if (freerun_check_select == aju_pkg::SEL_ERR) nxt_err.free_low = nxt_err.free_low | ev.free_low;
    else nxt_warn.free_low = nxt_warn.free_low | ev.free_low;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff  <= '0;
      warn_ff <= '0;
    end else if (clk_en) begin
      err_ff  <= nxt_err;
      warn_ff <= nxt_warn;
    end
  end

  // Output drive, all registered.
  logic any_err, any_warn, judged_ff, nxt_judged;
  assign any_err  = |nxt_err;
  assign any_warn = |nxt_warn;
  assign nxt_judged = judge_pt;

  always_comb begin
    nxt_out             = '0;
    nxt_out.fail_line   = any_err;
    nxt_out.pass_line   = !any_err && any_warn;
    nxt_out.valve_close = nxt_err.tot_high | stop_now;
    nxt_out.buzzer      = any_err | any_warn;
    nxt_out.lamp_off    = nxt_err.seat_trq | nxt_err.seat_low | nxt_err.seat_high
                          | nxt_err.free_low;
    nxt_out.count_dec   = judged_ff && !(|err_ff) && (|warn_ff);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff    <= '0;
      judged_ff <= 1'b0;
    end else if (clk_en) begin
      out_ff    <= nxt_out;
      judged_ff <= nxt_judged;
    end
  end

  assign fail_output_line = out_ff.fail_line;
  assign pass_output_line = out_ff.pass_line;
  assign buzzer           = out_ff.buzzer;
  assign valve_close      = out_ff.valve_close;
  assign count_dec        = out_ff.count_dec;
  assign torque_lamp_off  = out_ff.lamp_off;
  assign error_flags      = err_ff;

endmodule
`default_nettype wire

// File: bench/aju_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module aju_tool_model (
  // Clock.
  input  wire logic hclk,
  // Tool measurement toward the block.
  output logic        trigger,
  output logic        start_torque_hit,
  output logic [13:0] torque,
  output logic        angle_pulse,
  output logic        seat_timer_done,
  output logic        judge_now
);
  initial begin
    trigger = 1'b0;
    start_torque_hit = 1'b0;
    torque = 14'h0000;
    angle_pulse = 1'b0;
    seat_timer_done = 1'b0;
    judge_now = 1'b0;
  end

  // One degree per pulse, with a low cycle between so no edge is merged.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      angle_pulse <= 1'b1;
      @(posedge hclk);
      angle_pulse <= 1'b0;
    end
  endtask

  // One fastening: trigger, free run, start torque, seating, end, judgment.
  task automatic fasten(input int fr, input int sn, input int tt, input bit reach);
    @(posedge hclk);
    trigger <= 1'b1;
    @(posedge hclk);
    trigger <= 1'b0;
    pulses(fr);
    @(posedge hclk);
    start_torque_hit <= 1'b1;
    @(posedge hclk);
    start_torque_hit <= 1'b0;
    pulses(sn);
    @(posedge hclk);
    // Torque stops exactly on the threshold so the edge of the compare is exercised.
    if (reach) torque <= 14'h0064;
    else seat_timer_done <= 1'b1;
    @(posedge hclk);
    seat_timer_done <= 1'b0;
    pulses(tt);
    @(posedge hclk);
    judge_now <= 1'b1;
    @(posedge hclk);
    judge_now <= 1'b0;
    torque <= 14'h0000;
    repeat (4) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// File: bench/aju_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aju_checker (
  // Clock and reset.
  input wire logic       hclk,
  input wire logic       hresetn,
  // Causes.
  input wire logic       hsel,
  input wire logic       trigger,
  input wire logic       judge_now,
  input wire logic       seat_timer_done,
  input wire logic       ext_reset,
  input wire logic       panel_reset_key,
  // Watched outputs.
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       fail_output_line,
  input wire logic       pass_output_line,
  input wire logic       buzzer,
  input wire logic       valve_close,
  input wire logic       count_dec,
  input wire logic       torque_lamp_off,
  input wire logic [5:0] error_flags
);
  // A register write may be the control clear, so any select counts as a source.
  wire clr_src = ext_reset | panel_reset_key | trigger | hsel;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_fail_follows: assert property (fail_output_line == (|error_flags))
    else $error("fail line does not follow error flags");
  a_valve_close: assert property (valve_close == error_flags[5])
    else $error("valve does not follow total high error");
  a_lamp_cause: assert property (torque_lamp_off == (|error_flags[3:0]))
    else $error("lamp does not follow seating or free run errors");
  a_lamp_buzz: assert property (torque_lamp_off |-> buzzer)
    else $error("lamp off without buzzer");
  a_pass_excl: assert property (pass_output_line |-> !fail_output_line && buzzer)
    else $error("pass line with fail line or without buzzer");
  a_flag_judged: assert property ((error_flags & ~$past(error_flags) & 6'h17) != 6'h00 |->
    $past(judge_now))
    else $error("error flag set without judgment");
  a_seat_timer: assert property ($rose(error_flags[3]) |-> $past(seat_timer_done))
    else $error("seating torque error without timer expiry");
  a_flag_clear: assert property ((~error_flags & $past(error_flags)) != 6'h00 |->
    clr_src || $past(clr_src) || $past(clr_src, 2) || $past(clr_src, 3))
    else $error("error flag dropped without a clear");
  a_count_cause: assert property (count_dec |-> $past(judge_now, 2) && pass_output_line)
    else $error("count pulse not two cycles after warning judgment");
  a_count_pulse: assert property (count_dec |=> !count_dec)
    else $error("count pulse longer than one cycle");
endmodule
bind aju_angle_judgment aju_checker aju_checker_inst (.hclk, .hresetn, .hsel, .trigger,
  .judge_now, .seat_timer_done, .ext_reset, .panel_reset_key, .hreadyout, .hresp, .fail_output_line,
  .pass_output_line, .buzzer, .valve_close, .count_dec, .torque_lamp_off, .error_flags);
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite, ext_reset, panel_reset_key;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        hreadyout, hresp, trigger, start_torque_hit, angle_pulse;
  logic        seat_timer_done, judge_now, fail_output_line, pass_output_line;
  logic        buzzer, valve_close, count_dec, torque_lamp_off;
  logic [13:0] torque;
  logic [5:0]  error_flags;
  int          n_mismatch, total_checks, n_dec;

  aju_angle_judgment aju_angle_judgment_inst (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .trigger, .start_torque_hit, .torque, .angle_pulse, .seat_timer_done, .judge_now,
    .ext_reset, .panel_reset_key, .fail_output_line, .pass_output_line, .buzzer,
    .valve_close, .count_dec, .torque_lamp_off, .error_flags);
  aju_tool_model aju_tool_model_inst (.hclk, .trigger, .start_torque_hit, .torque,
    .angle_pulse, .seat_timer_done, .judge_now);

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (count_dec === 1'b1) n_dec++;

  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 20) begin
        n_mismatch++;
        close_out();
      end
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // One fastening under a configuration, then every verdict line is judged.
  task automatic judge(input logic [31:0] cfg, input int fr, input int sn, input int tt,
                       input bit reach, input logic [5:0] ef, input logic wn);
    int d0;
    wr(aju_pkg::OFS_CFG, cfg);
    d0 = n_dec;
    aju_tool_model_inst.fasten(fr, sn, tt, reach);
    chk(error_flags, ef);
    chk(fail_output_line, |ef);
    chk(pass_output_line, wn & ~|ef);
    chk(buzzer, |ef | wn);
    chk(valve_close, ef[5]);
    chk(torque_lamp_off, |ef[3:0]);
    chk(32'(n_dec - d0), wn & ~|ef);
  endtask
  task automatic pulse_clr(input bit panel);
    @(posedge hclk);
    if (panel) panel_reset_key <= 1'b1;
    else ext_reset <= 1'b1;
    @(posedge hclk);
    panel_reset_key <= 1'b0;
    ext_reset <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic s_regs;
    chk(error_flags, 6'h00);
    rd_chk(aju_pkg::OFS_CFG, 32'h0);
    rd_chk(aju_pkg::OFS_SEAT_LIM, 32'h03e7_0000);
    rd_chk(aju_pkg::OFS_SEAT_TRQ, 32'h03e7_0000);
    rd_chk(8'h24, 32'h0);
    wr(aju_pkg::OFS_TOT_LIM, 32'h000a_0005);
    wr(aju_pkg::OFS_SEAT_LIM, 32'h0008_0003);
    wr(aju_pkg::OFS_FREE_LIM, 32'h0000_0005);
    wr(aju_pkg::OFS_SEAT_TRQ, 32'h03e7_0064);
    rd_chk(aju_pkg::OFS_TOT_LIM, 32'h000a_0005);
  endtask
  task automatic s_total;
    judge(32'hc1, 0, 4, 10, 1, 6'h00, 1'b0);
    judge(32'hc1, 0, 4, 11, 1, 6'h20, 1'b0);
    judge(32'hc1, 0, 4, 4, 1, 6'h10, 1'b0);
    judge(32'hc0, 0, 4, 11, 1, 6'h00, 1'b0);
    judge(32'hc2, 0, 4, 11, 1, 6'h00, 1'b1);
  endtask
  task automatic s_seat;
    judge(32'hd1, 0, 2, 10, 1, 6'h04, 1'b0);
    judge(32'hd1, 0, 9, 10, 1, 6'h02, 1'b0);
    judge(32'hd1, 0, 3, 10, 1, 6'h00, 1'b0);
    judge(32'hd1, 0, 8, 10, 1, 6'h00, 1'b0);
    judge(32'hd2, 0, 9, 10, 1, 6'h00, 1'b1);
  endtask
  task automatic s_seat_trq;
    judge(32'he1, 0, 4, 0, 0, 6'h18, 1'b0);
    judge(32'he1, 0, 4, 10, 1, 6'h00, 1'b0);
    judge(32'he2, 0, 4, 0, 0, 6'h00, 1'b1);
  endtask
  task automatic s_free;
    judge(32'hc4, 4, 4, 10, 1, 6'h01, 1'b0);
    judge(32'hc4, 5, 4, 10, 1, 6'h00, 1'b0);
    judge(32'hc8, 4, 4, 10, 1, 6'h00, 1'b1);
  endtask
  task automatic s_hold;
    judge(32'h01, 0, 4, 11, 1, 6'h20, 1'b0);
    repeat (20) @(posedge hclk);
    chk(fail_output_line, 1'b1);
    pulse_clr(1'b0);
    chk(error_flags, 6'h00);
    judge(32'h01, 0, 4, 11, 1, 6'h20, 1'b0);
    judge(32'h01, 0, 4, 10, 1, 6'h20, 1'b0);
    pulse_clr(1'b0);
    chk(error_flags, 6'h00);
    judge(32'h01, 0, 4, 4, 1, 6'h10, 1'b0);
    pulse_clr(1'b1);
    chk(error_flags, 6'h00);
    judge(32'h01, 0, 4, 4, 1, 6'h10, 1'b0);
    wr(aju_pkg::OFS_CONTROL, 32'h1);
    repeat (3) @(posedge hclk);
    chk(fail_output_line, 1'b0);
  endtask
  task automatic s_report;
    for (int r = 0; r < 4; r++) begin
      judge(32'h60c1 | (32'(r) << 8), 6, 4, 10, 1, 6'h00, 1'b0);
      rd_chk(aju_pkg::OFS_ANGLES, r[0] ? 32'h0004_000a : 32'h0000_000a);
      rd_chk(aju_pkg::OFS_FREE_ANGLE, r[1] ? 32'h0000_0006 : 32'h0);
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_reset = 1'b0;
    panel_reset_key = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    n_dec = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs();
    s_total();
    s_seat();
    s_seat_trq();
    s_free();
    s_hold();
    s_report();
    close_out();
  end
endmodule
`default_nettype wire
